// file: rtl/tdrh_consts.svh
// Constants of the trigger delay and reading hold sequencer
`ifndef TDRH_CONSTS_SVH
`define TDRH_CONSTS_SVH
// ****************************************
// Timing
// ****************************************
`define TDRH_CLK_PERIOD_NS 25
`define TDRH_TICK_NS 1000000
`define TDRH_TICK_CYCLES (`TDRH_TICK_NS / `TDRH_CLK_PERIOD_NS)
`define TDRH_VMC_NS 10000
`define TDRH_VMC_CYCLES ((`TDRH_VMC_NS + `TDRH_CLK_PERIOD_NS - 1) / `TDRH_CLK_PERIOD_NS)
`define TDRH_DLY_W 29
`define TDRH_HOUR_MS 32'h0036_EE80
`define TDRH_MIN_MS 32'h0000_EA60
// ****************************************
// Register map
// ****************************************
`define TDRH_A_CTRL 8'h00
`define TDRH_A_FUNC 8'h04
`define TDRH_A_MDLY 8'h08
`define TDRH_A_CNT 8'h0C
`define TDRH_A_STAT 8'h10
`define TDRH_A_RDG 8'h14
`define TDRH_CTRL_W 13
`define TDRH_B_RUN 0
`define TDRH_B_MANUAL 1
`define TDRH_B_SCAN 4
`define TDRH_B_REMOTE 5
`define TDRH_B_HOLD 6
`define TDRH_B_FILT 7
`define TDRH_B_MOVING 8
`define TDRH_B_PRESET 13
`define TDRH_CTRL_RST 13'h0001
`define TDRH_MDLY_1MS 31'h0000_4000
`define TDRH_CNT_RST 16'h0202
`define TDRH_MAX99 7'h63
`define TDRH_MAXMS 17'h1_869F
`define TDRH_HOLD_MIN 7'h02
`define TDRH_CNT_MAX 7'h64
// ****************************************
// Auto delays in ms
// ****************************************
`define TDRH_D1 16'h0001
`define TDRH_D2 16'h0002
`define TDRH_D3 16'h0003
`define TDRH_D5 16'h0005
`define TDRH_D13 16'h000D
`define TDRH_D25 16'h0019
`define TDRH_D100 16'h0064
`define TDRH_D150 16'h0096
`define TDRH_D250 16'h00FA
`define TDRH_D400 16'h0190
`define TDRH_D0 16'h0000
// ****************************************
// Hold window, fraction times 2^20
// ****************************************
`define TDRH_WIN_SHIFT 20
`define TDRH_WIN_0P01 17'h0_0069
`define TDRH_WIN_0P1 17'h0_0419
`define TDRH_WIN_1 17'h0_28F6
`define TDRH_WIN_10 17'h1_999A
`endif

// file: rtl/tdrh_pkg.sv
// Types and auto delay lookup of the sequencer
package tdrh_pkg;
`include "tdrh_consts.svh"
   typedef enum logic [1:0] {SRC_IMM, SRC_EXT, SRC_BUS, SRC_OTHER} tdrh_src_t;
   typedef enum logic [1:0] {BEEP_NEVER, BEEP_OUTSIDE, BEEP_INSIDE, BEEP_RSVD} tdrh_beep_t;
   typedef enum logic [1:0] {WIN_0P01, WIN_0P1, WIN_1, WIN_10} tdrh_win_t;
   typedef enum logic [3:0] {FN_DCV, FN_ACV, FN_FREQ, FN_DCI, FN_ACI, FN_OHM, FN_CONT,
      FN_TC, FN_THRM} tdrh_fn_t;
   typedef enum logic [3:0] {ST_IDLE, ST_ARM, ST_DELAY, ST_ACT, ST_CONV, ST_DIV, ST_HOLD,
      ST_CHAN, ST_CHWAIT, ST_TRIG} tdrh_state_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } tdrh_bus_t;
   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } tdrh_conv_t;

   function automatic logic [15:0] tdrh_ohm_dly(input logic [2:0] rng);
      case (rng)
         3'h0, 3'h1: return `TDRH_D3;
         3'h2: return `TDRH_D13;
         3'h3: return `TDRH_D25;
         3'h4: return `TDRH_D100;
         3'h5: return `TDRH_D150;
         default: return `TDRH_D250;
      endcase
   endfunction

   function automatic logic [15:0] tdrh_auto_dly(input logic [3:0] fn, input logic [2:0] rng);
      case (fn)
         FN_DCV: return (rng < 3'h3) ? `TDRH_D1 : `TDRH_D5;
         FN_ACV, FN_ACI: return `TDRH_D400;
         FN_FREQ: return `TDRH_D1;
         FN_DCI: return `TDRH_D2;
         FN_OHM, FN_THRM: return tdrh_ohm_dly(rng);
         FN_CONT: return `TDRH_D3;
         FN_TC: return `TDRH_D1;
         default: return `TDRH_D0;
      endcase
   endfunction
endpackage

// file: rtl/tdrh_top.sv
// Trigger delay, device action and reading hold sequencer
//
// Decided for this implementation: strobed register access and the register offsets.
`include "tdrh_consts.svh"
module tdrh_top
   import tdrh_pkg::*;
#(
   parameter int TICK_CYCLES = `TDRH_TICK_CYCLES,
   parameter int VMC_CYCLES = `TDRH_VMC_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire tdrh_bus_t bus,
   output logic [31:0] rd_data,
   input wire logic ext_trig_n,
   input wire logic trig_key,
   input wire logic bus_trg,
   input wire logic other_evt,
   input wire tdrh_conv_t conv,
   output logic conv_start,
   output logic chan_step,
   input wire logic chan_done,
   output logic vmc_out_n,
   output logic beep,
   output logic rdg_valid,
   output logic [23:0] rdg_data,
   output logic held
);
   // ****************************************
   // Register file
   // ****************************************
   logic [`TDRH_CTRL_W-1:0] ctrl, next_ctrl;
   logic [7:0] func, next_func;
   logic [30:0] mdly, next_mdly;
   logic [15:0] cnt, next_cnt;
   logic [31:0] next_rd_data;
   tdrh_state_t state, next_state;
   logic seeded, mov_full;
   logic [6:0] hcnt, next_hcnt;
   function automatic logic [6:0] lim99(input logic [6:0] v);
      return (v > `TDRH_MAX99) ? `TDRH_MAX99 : v;
   endfunction
   always_comb begin
      next_ctrl = ctrl;
      next_func = func;
      next_mdly = mdly;
      next_cnt = cnt;
      next_rd_data = 32'h0000_0000;
      if (bus.wr) begin
         case (bus.addr)
            `TDRH_A_CTRL: begin
               next_ctrl = bus.wdata[`TDRH_CTRL_W-1:0];
               if (bus.wdata[`TDRH_B_PRESET]) begin
                  next_mdly = `TDRH_MDLY_1MS;
               end
            end
            `TDRH_A_FUNC: next_func = bus.wdata[7:0];
            `TDRH_A_MDLY: begin
               // Fields clamp so the total never passes 99:99:99.999
               next_mdly[6:0] = lim99(bus.wdata[6:0]);
               next_mdly[13:7] = lim99(bus.wdata[13:7]);
               next_mdly[30:14] = (bus.wdata[30:14] > `TDRH_MAXMS) ? `TDRH_MAXMS :
                  bus.wdata[30:14];
            end
            `TDRH_A_CNT: next_cnt = bus.wdata[15:0];
            default: next_cnt = cnt;
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            `TDRH_A_CTRL: next_rd_data = {19'h0_0000, ctrl};
            `TDRH_A_FUNC: next_rd_data = {24'h00_0000, func};
            `TDRH_A_MDLY: next_rd_data = {1'b0, mdly};
            `TDRH_A_CNT: next_rd_data = {16'h0000, cnt};
            `TDRH_A_STAT: next_rd_data = {17'h0_0000, hcnt, 1'b0, mov_full, seeded, held,
               4'(state)};
            `TDRH_A_RDG: next_rd_data = {{8{rdg_data[23]}}, rdg_data};
            default: next_rd_data = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl <= `TDRH_CTRL_RST;
         func <= 8'h00;
         mdly <= `TDRH_MDLY_1MS;
         cnt <= `TDRH_CNT_RST;
         rd_data <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         func <= next_func;
         mdly <= next_mdly;
         cnt <= next_cnt;
         rd_data <= next_rd_data;
      end
   end

   // ****************************************
   // Decoded settings
   // ****************************************
   logic run, manual, scanning, remote, hold_act, filt_en, moving, auto_on;
   tdrh_src_t src;
   tdrh_win_t win;
   tdrh_beep_t beep_mode;
   logic [6:0] filt_n, hold_n;
   logic [31:0] man_ms;
   logic [15:0] auto_ms;
   assign run = ctrl[`TDRH_B_RUN];
   assign manual = ctrl[`TDRH_B_MANUAL];
   assign src = tdrh_src_t'(ctrl[3:2]);
   assign scanning = ctrl[`TDRH_B_SCAN];
   assign remote = ctrl[`TDRH_B_REMOTE];
   assign hold_act = ctrl[`TDRH_B_HOLD] & ~scanning;
   assign filt_en = ctrl[`TDRH_B_FILT];
   assign moving = ctrl[`TDRH_B_MOVING];
   assign win = tdrh_win_t'(ctrl[10:9]);
   assign beep_mode = tdrh_beep_t'(ctrl[12:11]);
   assign filt_n = (cnt[6:0] == 7'h00) ? 7'h01 :
      (cnt[6:0] > `TDRH_CNT_MAX) ? `TDRH_CNT_MAX : cnt[6:0];
   assign hold_n = (cnt[14:8] < `TDRH_HOLD_MIN) ? `TDRH_HOLD_MIN :
      (cnt[14:8] > `TDRH_CNT_MAX) ? `TDRH_CNT_MAX : cnt[14:8];
   assign man_ms = 32'(mdly[6:0]) * `TDRH_HOUR_MS + 32'(mdly[13:7]) * `TDRH_MIN_MS +
      32'(mdly[30:14]);
   assign auto_on = scanning | (src == SRC_EXT) | (src == SRC_BUS);
   assign auto_ms = auto_on ? tdrh_auto_dly(func[3:0], func[6:4]) : `TDRH_D0;

   // ****************************************
   // Sequencer
   // ****************************************
   logic [31:0] tick_cnt, next_tick_cnt, acc, next_acc, quo, next_quo, acc_sum;
   logic [31:0] vmc_cnt, next_vmc_cnt;
   logic [`TDRH_DLY_W-1:0] dly_cnt, next_dly_cnt, dly_load;
   logic [6:0] conv_cnt, next_conv_cnt, tgt, next_tgt, rem, next_rem;
   logic [5:0] div_cnt, next_div_cnt;
   logic [23:0] rdg, next_rdg, seed, next_seed, next_rdg_data;
   logic neg, next_neg, next_seeded, next_mov_full, next_held, ext_prev, event_hit, in_win;
   logic next_conv_start, next_chan_step, next_vmc_out_n, next_beep, next_rdg_valid;
   logic [7:0] trial;
   logic [24:0] seed_abs, diff, diff_abs;
   logic [16:0] win_num;
   logic [41:0] tol;
   // The link input is synchronous; a falling edge marks a trigger
   always_comb begin
      unique case (src)
         SRC_IMM: event_hit = 1'b1;
         SRC_EXT: event_hit = (ext_prev & ~ext_trig_n) | trig_key | bus_trg;
         SRC_BUS: event_hit = bus_trg;
         SRC_OTHER: event_hit = other_evt;
      endcase
   end
   assign dly_load = manual ? man_ms[`TDRH_DLY_W-1:0] : `TDRH_DLY_W'(auto_ms);
   assign acc_sum = acc + {{8{conv.data[23]}}, conv.data};
   assign trial = {rem, quo[31]};
   // Tolerance is an approximate fraction of the seed magnitude
   always_comb begin
      unique case (win)
         WIN_0P01: win_num = `TDRH_WIN_0P01;
         WIN_0P1: win_num = `TDRH_WIN_0P1;
         WIN_1: win_num = `TDRH_WIN_1;
         WIN_10: win_num = `TDRH_WIN_10;
      endcase
   end
   assign seed_abs = seed[23] ? 25'(-{seed[23], seed}) : {1'b0, seed};
   assign diff = {rdg[23], rdg} - {seed[23], seed};
   assign diff_abs = diff[24] ? 25'(-diff) : diff;
   assign tol = 42'(seed_abs) * 42'(win_num);
   assign in_win = diff_abs <= 25'(tol[41:`TDRH_WIN_SHIFT]);
   always_comb begin
      next_state = state;
      next_tick_cnt = tick_cnt;
      next_dly_cnt = dly_cnt;
      next_conv_cnt = conv_cnt;
      next_tgt = tgt;
      next_acc = acc;
      next_quo = quo;
      next_rem = rem;
      next_div_cnt = div_cnt;
      next_neg = neg;
      next_rdg = rdg;
      next_seed = seed;
      next_seeded = seeded;
      next_mov_full = mov_full & moving & filt_en;
      next_hcnt = hcnt;
      next_held = held;
      next_vmc_cnt = vmc_cnt;
      next_conv_start = 1'b0;
      next_chan_step = 1'b0;
      next_vmc_out_n = 1'b1;
      next_beep = 1'b0;
      next_rdg_valid = 1'b0;
      next_rdg_data = rdg_data;
      unique case (state)
         ST_IDLE: next_state = run ? ST_ARM : ST_IDLE;
         ST_ARM: begin
            if (!run) begin
               next_state = ST_IDLE;
            end else if (event_hit) begin
               next_dly_cnt = dly_load;
               next_tick_cnt = 32'h0000_0000;
               next_state = (dly_load == '0) ? ST_ACT : ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
               next_tick_cnt = 32'h0000_0000;
               next_dly_cnt = dly_cnt - 1'b1;
               if (dly_cnt == `TDRH_DLY_W'(1)) begin
                  next_state = ST_ACT;
               end
            end else begin
               next_tick_cnt = tick_cnt + 32'h0000_0001;
            end
         end
         ST_ACT: begin
            next_tgt = (filt_en && !(moving && mov_full)) ? filt_n : 7'h01;
            next_acc = 32'h0000_0000;
            next_conv_cnt = 7'h00;
            next_conv_start = 1'b1;
            next_state = ST_CONV;
         end
         ST_CONV: begin
            if (conv.valid) begin
               next_acc = acc_sum;
               next_conv_cnt = conv_cnt + 7'h01;
               if (conv_cnt + 7'h01 >= tgt) begin
                  next_mov_full = filt_en & moving;
                  next_neg = acc_sum[31];
                  next_quo = acc_sum[31] ? -acc_sum : acc_sum;
                  next_rem = 7'h00;
                  next_div_cnt = 6'h00;
                  next_state = ST_DIV;
               end else begin
                  next_conv_start = 1'b1;
               end
            end
         end
         ST_DIV: begin
            // Serial divide keeps the averager small at 32 cycles per reading
            if (trial >= {1'b0, tgt}) begin
               next_rem = 7'(trial - {1'b0, tgt});
               next_quo = {quo[30:0], 1'b1};
            end else begin
               next_rem = trial[6:0];
               next_quo = {quo[30:0], 1'b0};
            end
            next_div_cnt = div_cnt + 6'h01;
            if (div_cnt == 6'h1F) begin
               next_rdg = neg ? 24'(-next_quo) : next_quo[23:0];
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!hold_act) begin
               next_rdg_valid = 1'b1;
               next_rdg_data = rdg;
               next_held = 1'b0;
               next_state = ST_CHAN;
            end else if (!seeded) begin
               next_seed = rdg;
               next_seeded = 1'b1;
               next_hcnt = 7'h00;
               next_state = ST_ACT;
            end else if (!in_win) begin
               next_seed = rdg;
               next_hcnt = 7'h00;
               next_held = 1'b0;
               next_beep = (beep_mode == BEEP_OUTSIDE);
               next_state = ST_ACT;
            end else if (held) begin
               // Front panel hold stays put until the signal leaves the window
               next_state = ST_ACT;
            end else if (hcnt + 7'h01 >= hold_n) begin
               next_hcnt = 7'h00;
               next_rdg_valid = 1'b1;
               next_rdg_data = rdg;
               next_beep = (beep_mode == BEEP_INSIDE);
               next_held = ~remote;
               next_seeded = ~remote;
               next_state = ST_CHAN;
            end else begin
               next_hcnt = hcnt + 7'h01;
               next_state = ST_ACT;
            end
         end
         ST_CHAN: begin
            if (scanning) begin
               next_chan_step = 1'b1;
               next_state = ST_CHWAIT;
            end else begin
               next_vmc_cnt = 32'(VMC_CYCLES - 1);
               next_vmc_out_n = 1'b0;
               next_state = ST_TRIG;
            end
         end
         ST_CHWAIT: begin
            if (chan_done) begin
               next_seeded = 1'b0;
               next_hcnt = 7'h00;
               next_held = 1'b0;
               next_vmc_cnt = 32'(VMC_CYCLES - 1);
               next_vmc_out_n = 1'b0;
               next_state = ST_TRIG;
            end
         end
         ST_TRIG: begin
            if (vmc_cnt == 32'h0000_0000) begin
               next_state = run ? ST_ARM : ST_IDLE;
            end else begin
               next_vmc_out_n = 1'b0;
               next_vmc_cnt = vmc_cnt - 32'h0000_0001;
            end
         end
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         tick_cnt <= 32'h0000_0000;
         dly_cnt <= '0;
         conv_cnt <= 7'h00;
         tgt <= 7'h01;
         acc <= 32'h0000_0000;
         quo <= 32'h0000_0000;
         rem <= 7'h00;
         div_cnt <= 6'h00;
         neg <= 1'b0;
         rdg <= 24'h00_0000;
         seed <= 24'h00_0000;
         seeded <= 1'b0;
         mov_full <= 1'b0;
         hcnt <= 7'h00;
         held <= 1'b0;
         vmc_cnt <= 32'h0000_0000;
         conv_start <= 1'b0;
         chan_step <= 1'b0;
         vmc_out_n <= 1'b1;
         beep <= 1'b0;
         rdg_valid <= 1'b0;
         rdg_data <= 24'h00_0000;
         ext_prev <= 1'b1;
      end else begin
         state <= next_state;
         tick_cnt <= next_tick_cnt;
         dly_cnt <= next_dly_cnt;
         conv_cnt <= next_conv_cnt;
         tgt <= next_tgt;
         acc <= next_acc;
         quo <= next_quo;
         rem <= next_rem;
         div_cnt <= next_div_cnt;
         neg <= next_neg;
         rdg <= next_rdg;
         seed <= next_seed;
         seeded <= next_seeded;
         mov_full <= next_mov_full;
         hcnt <= next_hcnt;
         held <= next_held;
         vmc_cnt <= next_vmc_cnt;
         conv_start <= next_conv_start;
         chan_step <= next_chan_step;
         vmc_out_n <= next_vmc_out_n;
         beep <= next_beep;
         rdg_valid <= next_rdg_valid;
         rdg_data <= next_rdg_data;
         ext_prev <= ext_trig_n;
      end
   end
endmodule

// file: tb/tdrh_conv_model.sv
// Converter and scanner model at the far side
module tdrh_conv_model
   import tdrh_pkg::*;
(
   input wire logic sys_clk,
   input wire logic conv_start,
   input wire logic chan_step,
   output tdrh_conv_t conv,
   output logic chan_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] vals [0:15];
   int idx = 0;
   initial begin
      conv = '0;
      chan_done = 0;
      foreach (vals[i]) vals[i] = 24'h00_0802;
   end
   // ****
   // Answers
   // ****
   // Odd conversions answer slowly
   always @(posedge sys_clk) begin
      if (conv_start) begin
         repeat (1 + 5 * (idx % 2)) @(posedge sys_clk);
         conv <= '{1'b1, vals[idx < 16 ? idx : 15]};
         idx <= idx + 1;
         @(posedge sys_clk);
         // Data not held after the strobe
         conv <= '{1'b0, ~conv.data};
      end
   end
   always @(posedge sys_clk) begin
      if (chan_step) begin
         repeat (3) @(posedge sys_clk);
         chan_done <= 1;
         @(posedge sys_clk);
         chan_done <= 0;
      end
   end
endmodule

// file: tb/tdrh_monitor.sv
// Port checks of the sequencer
module tdrh_monitor
   import tdrh_pkg::*;
#(
   parameter int VMC_CYCLES = 3
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conv_start,
   input wire logic chan_step,
   input wire logic vmc_out_n,
   input wire logic beep,
   input wire logic rdg_valid,
   input wire logic [23:0] rdg_data
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // Checks
   // ****
   int low_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Counter, since the width is a parameter
   always_ff @(posedge sys_clk) begin
      if (sys_rst || vmc_out_n) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end
   trig_width_a: assert property ($rose(vmc_out_n) |-> low_cnt == VMC_CYCLES)
      else $error("output trigger width wrong");
   rel_trig_a: assert property (rdg_valid |-> ##[1:2] ($fell(vmc_out_n) || chan_step))
      else $error("no trigger after release");
   conv_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("conversion request too long");
   chan_pulse_a: assert property (chan_step |=> !chan_step)
      else $error("channel step too long");
   beep_pulse_a: assert property (beep |=> !beep)
      else $error("beep too long");
   rdg_keep_a: assert property (!rdg_valid |-> $stable(rdg_data))
      else $error("reading changed without release");
   trig_idle_a: assert property (conv_start |-> vmc_out_n)
      else $error("trigger during action");
   chan_first_a: assert property (chan_step |=> vmc_out_n [*2])
      else $error("trigger before relay settled");
   cover property (rdg_valid);
   cover property (beep);
   cover property (chan_step ##[1:20] !vmc_out_n);
endmodule

bind tdrh_top tdrh_monitor #(.VMC_CYCLES(VMC_CYCLES)) u_tdrh_monitor (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .conv_start(conv_start), .chan_step(chan_step), .vmc_out_n(vmc_out_n),
   .beep(beep), .rdg_valid(rdg_valid), .rdg_data(rdg_data));

// file: tb/tdrh_test.sv
// Self-checking bench of the sequencer
module tdrh_test
   import tdrh_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0;
   logic sys_rst, ext_trig_n, trig_key, bus_trg, other_evt;
   tdrh_bus_t bus;
   tdrh_conv_t conv;
   logic [31:0] rd_data;
   logic conv_start, chan_step, chan_done, vmc_out_n, beep, rdg_valid, held;
   logic [23:0] rdg_data;
   logic [31:0] seed = 32'h0000_f242;
   logic signed [23:0] a [0:2];
   int hv [5] = '{1000, 1050, 2000, 2100, 2050};
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int nconv, nbeep, nrdg, nchan, base, lat, f, r;
   always #12.5 sys_clk = ~sys_clk;
   tdrh_top #(.TICK_CYCLES(4), .VMC_CYCLES(3)) u_tdrh_top (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data), .ext_trig_n(ext_trig_n),
      .trig_key(trig_key), .bus_trg(bus_trg), .other_evt(other_evt), .conv(conv),
      .conv_start(conv_start), .chan_step(chan_step), .chan_done(chan_done),
      .vmc_out_n(vmc_out_n), .beep(beep), .rdg_valid(rdg_valid), .rdg_data(rdg_data),
      .held(held));
   tdrh_conv_model u_tdrh_conv_model (.sys_clk(sys_clk), .conv_start(conv_start),
      .chan_step(chan_step), .conv(conv), .chan_done(chan_done));
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic int want(input int f, input int r);
      case (f)
         0: return r < 3 ? 1 : 5;
         1, 4: return 400;
         3: return 2;
         5, 8: return r < 2 ? 3 : r == 2 ? 13 : r == 3 ? 25 : r == 4 ? 100 : r == 5 ? 150 : 250;
         6: return 3;
         default: return 1;
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      bus <= '{1'b1, 1'b0, ad, d};
      @(posedge sys_clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      @(posedge sys_clk);
      bus <= '{1'b0, 1'b1, ad, 32'h0000_0000};
      @(posedge sys_clk);
      bus <= '0;
      #1 chk("rd_data", rd_data, e);
   endtask
   task automatic cfg(input logic [31:0] c, input logic [31:0] fn, input logic [31:0] cn);
      wr(8'h00, c);
      wr(8'h04, fn);
      wr(8'h0C, cn);
      repeat (100) @(posedge sys_clk);
   endtask
   // One event, then watch until the output trigger
   task automatic run(input int ev);
      int n;
      {nconv, nbeep, nrdg, nchan, lat} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
      @(posedge sys_clk);
      case (ev)
         0: trig_key <= 1;
         1: ext_trig_n <= 0;
         2: bus_trg <= 1;
         default: other_evt <= 1;
      endcase
      @(posedge sys_clk);
      {trig_key, ext_trig_n, bus_trg, other_evt} <= 4'b0100;
      for (n = 0; n < 3000 && vmc_out_n !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
         if (conv_start === 1'b1 && lat < 0) lat = n;
         nconv += conv_start;
         nbeep += beep;
         nrdg += rdg_valid;
         nchan += chan_step;
      end
      chk("output trigger", vmc_out_n, 32'h0000_0000);
      repeat (10) @(posedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ****
   // Scenarios
   // ****
   initial begin
      {bus, sys_rst, ext_trig_n, trig_key, bus_trg, other_evt} = {42'h0, 5'b11000};
      repeat (20) @(posedge sys_clk);
      sys_rst <= 0;
      rd(8'h00, 32'h0000_0001);
      rd(8'h08, 32'h0000_4000);
      rd(8'h0C, 32'h0000_0202);
      rd(8'h18, 32'h0000_0000);
      wr(8'h08, 32'h0000_007F);
      rd(8'h08, 32'h0000_0063);
      wr(8'h00, 32'h0000_2005);
      rd(8'h08, 32'h0000_4000);
      wr(8'h08, 32'h0000_0000);
      cfg(32'h0000_0007, 32'h0000_0000, 32'h0000_0202);
      run(0);
      base = lat;
      wr(8'h08, 32'h0001_C000);
      run(0);
      chk("manual delay", lat, base + 28);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         f = i < 2 ? 0 : seed % 9;
         r = i < 2 ? 2 + i : (seed >> 8) % 7;
         cfg(32'h0000_0005, f + r * 16, 32'h0000_0202);
         run(0);
         chk("auto delay", lat, base + want(f, r) * 4);
      end
      run(1);
      chk("link event", nrdg, 1);
      cfg(32'h0000_0009, 32'h0000_0030, 32'h0000_0202);
      run(2);
      chk("bus delay", lat, base + 20);
      wr(8'h08, 32'h0000_0000);
      cfg(32'h0000_000F, 32'h0000_0001, 32'h0000_0202);
      run(3);
      f = lat;
      cfg(32'h0000_000D, 32'h0000_0001, 32'h0000_0202);
      run(3);
      chk("other auto", lat, f);
      cfg(32'h0000_005D, 32'h0000_0030, 32'h0000_0202);
      run(3);
      chk("scan delay", lat, f + 20);
      chk("scan convs", nconv, 1);
      chk("scan step", nchan, 1);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         a[i] = {{4{seed[19]}}, seed[19:0]};
         u_tdrh_conv_model.vals[i] = a[i];
      end
      u_tdrh_conv_model.idx = 0;
      cfg(32'h0000_0085, 32'h0000_0000, 32'h0000_0203);
      run(0);
      chk("filter convs", nconv, 3);
      chk("filter rdg", rdg_data, 24'((a[0] + a[1] + a[2]) / 3));
      cfg(32'h0000_0185, 32'h0000_0000, 32'h0000_0203);
      run(0);
      chk("moving first", nconv, 3);
      run(0);
      chk("moving full", nconv, 1);
      foreach (hv[i]) u_tdrh_conv_model.vals[i] = 24'(hv[i]);
      for (int m = 0; m < 3; m++) begin
         u_tdrh_conv_model.idx = 0;
         cfg(32'h0000_0665 | (m << 11), 32'h0000_0000, 32'h0000_0201);
         run(0);
         chk("hold convs", nconv, 5);
         chk("hold beeps", nbeep, m > 0);
         chk("hold release", nrdg, 1);
      end
      u_tdrh_conv_model.idx = 0;
      cfg(32'h0000_0645, 32'h0000_0000, 32'h0000_0201);
      run(0);
      chk("held", held, 1);
      f = 0;
      r = 0;
      @(posedge sys_clk);
      trig_key <= 1;
      @(posedge sys_clk);
      trig_key <= 0;
      repeat (300) begin
         @(posedge sys_clk);
         #1 f += (vmc_out_n === 1'b0) + (rdg_valid === 1'b1);
         r += (conv_start === 1'b1);
      end
      chk("held trig", f, 0);
      chk("held loop", r > 0, 1);
      report_and_stop();
   end
endmodule
